// ===== rtl/cmsb_pkg.sv
// Package for the call mode and stack bank select block.
// Assumes a 4-bit data memory bus and a 14-bit program counter in the core.
package cmsb_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] STACK_BANK_MODE_SELECT_ADDR = 12'hf84;
    localparam int          CALL_MODE_BIT_POS           = 3;
    localparam int          RESERVED_ZERO_BIT_POS       = 2;
    localparam int          STACK_BANK_SEL_HI_POS       = 1;
    localparam int          STACK_BANK_SEL_LO_POS       = 0;
    localparam logic [3:0]  SBMS_RESET_VALUE            = 4'h8;

    // ------------------------------------------------------------------
    // Stack and timing figures
    // ------------------------------------------------------------------
    localparam logic [1:0]  LEGACY_STACK_BYTES          = 2'h2;
    localparam logic [1:0]  EXTENDED_STACK_BYTES        = 2'h3;
    localparam logic [2:0]  LEGACY_ABS_CALL_CYCLES      = 3'h3;
    localparam logic [2:0]  EXTENDED_ABS_CALL_CYCLES    = 3'h4;
    localparam logic [2:0]  LEGACY_FIXED_CALL_CYCLES    = 3'h2;
    localparam logic [2:0]  EXTENDED_FIXED_CALL_CYCLES  = 3'h3;
    localparam int          PC_WIDTH                    = 14;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic {
        LEGACY_CALL_MODE,
        EXTENDED_CALL_MODE
    } cmsb_mode_t;

    typedef enum logic [1:0] {
        CALL_NONE,
        CALL_ABSOLUTE,
        CALL_FIXED_AREA,
        CALL_LONG_RANGE
    } cmsb_call_t;
endpackage

// ===== rtl/cmsb_call_timer.sv
// Counts the machine cycles of one call instruction.
// Assumes the core holds its sequencer while busy is high.
`timescale 1ns/1ps
`default_nettype none
module cmsb_call_timer (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Call request
    input  wire logic       start,
    input  wire logic [2:0] length,
    // Status
    output logic            busy,
    output logic            done
);
    logic [2:0] remain_reg;
    logic [2:0] remain_next;
    logic       done_reg;
    logic       done_next;

    // Load the cycle count on start, then count down to the last cycle.
    always_comb begin
        remain_next = remain_reg;
        done_next   = 1'b0;
        if (remain_reg != 3'h0) begin
            remain_next = remain_reg - 3'h1;
            done_next   = (remain_reg == 3'h1);
        end else if (start) begin
            remain_next = length;
        end
    end

    // State registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            remain_reg <= 3'h0;
            done_reg   <= 1'b0;
        end else begin
            remain_reg <= remain_next;
            done_reg   <= done_next;
        end
    end

    assign busy = (remain_reg != 3'h0);
    assign done = done_reg;
endmodule
`default_nettype wire

// ===== rtl/cmsb_mode_select.sv
// Call mode and stack bank select register with its effects on the core.
// Assumes a 4-bit data memory write/read port and one machine cycle per clk.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Mode bit 3 set picks legacy call mode; cleared picks extended mode.
// - Stack entries take two bytes in legacy mode, three in extended mode.
// - Absolute call 3 or 4 cycles; fixed-area call 2 or 3 cycles.
// - Long-range branch and call work only in extended mode.
// - Low two bits pick stack bank 0 to 2; value 3 is prohibited.
// - Reset sets the mode bit, so the core starts in legacy mode.
// - The register sits at data address F84, written four bits at once.
// - Program counter is a 14-bit binary counter over 16384 bytes.
module cmsb_mode_select (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Data memory port
    input  wire logic [11:0] memAddr,
    input  wire logic        memWrite,
    input  wire logic        memRead,
    input  wire logic [3:0]  memWdata,
    output logic      [3:0]  memRdata,
    output logic             memHit,
    // Instruction decode
    input  wire logic        callStart,
    input  wire cmsb_pkg::cmsb_call_t callKind,
    input  wire logic        longBranchReq,
    // Program counter control
    input  wire logic        pcLoad,
    input  wire logic [13:0] pcLoadValue,
    input  wire logic        pcStep,
    output logic      [13:0] programCounter,
    // Mode and stack outputs
    output logic             extendedMode,
    output logic      [1:0]  stackBank,
    output logic      [1:0]  stackEntryBytes,
    output logic             longInstrAllowed,
    output logic             illegalLongInstr,
    output logic             bankSelectFault,
    output logic             configured,
    output logic             callBusy,
    output logic             callDone
);
    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [3:0]  sbmsReg;
    logic [3:0]  sbmsNext;
    logic        configuredReg;
    logic        configuredNext;
    logic        regHit;
    logic [3:0]  effValue;

    // Address decode for the single mapped register.
    always_comb begin
        if (memAddr == cmsb_pkg::STACK_BANK_MODE_SELECT_ADDR) begin
            regHit = 1'b1;
        end else begin
            regHit = 1'b0;
        end
    end

    // Whole nibble written at once; bit 2 is kept as written and software must leave it zero.
    always_comb begin
        sbmsNext       = sbmsReg;
        configuredNext = configuredReg;
        if (memWrite && regHit) begin
            sbmsNext       = memWdata;
            configuredNext = 1'b1;
        end
    end

    // Reset value puts the core in legacy mode.
    always_ff @(posedge clk) begin
        if (rst) begin
            sbmsReg       <= cmsb_pkg::SBMS_RESET_VALUE;
            configuredReg <= 1'b0;
        end else begin
            sbmsReg       <= sbmsNext;
            configuredReg <= configuredNext;
        end
    end

    // Writes pass straight through, so a call in the same cycle already sees them.
    assign effValue = sbmsNext;

    // Read data is registered to keep the data path glitch free.
    logic [3:0] rdataReg;
    logic [3:0] rdataNext;
    always_comb begin
        rdataNext = 4'h0;
        if (memRead && regHit) begin
            rdataNext = sbmsReg;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            rdataReg <= 4'h0;
        end else begin
            rdataReg <= rdataNext;
        end
    end
    assign memRdata = rdataReg;
    assign memHit   = regHit;

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    // Mode bit set means legacy, cleared means extended.
    function automatic cmsb_pkg::cmsb_mode_t decodeMode(input logic [3:0] v);
        if (v[cmsb_pkg::CALL_MODE_BIT_POS]) begin
            decodeMode = cmsb_pkg::LEGACY_CALL_MODE;
        end else begin
            decodeMode = cmsb_pkg::EXTENDED_CALL_MODE;
        end
    endfunction

    cmsb_pkg::cmsb_mode_t mode;
    assign mode         = decodeMode(effValue);
    assign extendedMode = (mode == cmsb_pkg::EXTENDED_CALL_MODE);

    // Bank 3 does not exist; it is flagged, and the stack falls back to bank 0.
    always_comb begin
        bankSelectFault = (effValue[cmsb_pkg::STACK_BANK_SEL_HI_POS] &&
                           effValue[cmsb_pkg::STACK_BANK_SEL_LO_POS]);
        if (bankSelectFault) begin
            stackBank = 2'h0;
        end else begin
            stackBank = {effValue[cmsb_pkg::STACK_BANK_SEL_HI_POS],
                         effValue[cmsb_pkg::STACK_BANK_SEL_LO_POS]};
        end
    end

    // Stack entry width follows the mode.
    assign stackEntryBytes = extendedMode ? cmsb_pkg::EXTENDED_STACK_BYTES
                                          : cmsb_pkg::LEGACY_STACK_BYTES;

    // Long-range instructions are only legal once extended mode is chosen.
    assign longInstrAllowed = extendedMode;
    always_comb begin
        illegalLongInstr = 1'b0;
        if (!extendedMode &&
            (longBranchReq || (callStart && callKind == cmsb_pkg::CALL_LONG_RANGE))) begin
            illegalLongInstr = 1'b1;
        end
    end

    // Hardware cannot force software ordering; it only reports whether the register was written.
    assign configured = configuredReg;

    // ------------------------------------------------------------------
    // Call timing
    // ------------------------------------------------------------------
    logic [2:0] callLength;
    logic       timerStart;

    // Cycle count for each kind of call; extended mode adds one cycle.
    always_comb begin
        case (callKind)
            cmsb_pkg::CALL_ABSOLUTE: begin
                callLength = extendedMode ? cmsb_pkg::EXTENDED_ABS_CALL_CYCLES
                                          : cmsb_pkg::LEGACY_ABS_CALL_CYCLES;
            end
            cmsb_pkg::CALL_FIXED_AREA: begin
                callLength = extendedMode ? cmsb_pkg::EXTENDED_FIXED_CALL_CYCLES
                                          : cmsb_pkg::LEGACY_FIXED_CALL_CYCLES;
            end
            cmsb_pkg::CALL_LONG_RANGE: begin
                callLength = cmsb_pkg::EXTENDED_ABS_CALL_CYCLES;
            end
            default: begin
                callLength = 3'h0;
            end
        endcase
    end

    // Refused long calls and empty kinds never start the timer.
    assign timerStart = callStart && (callLength != 3'h0) && !illegalLongInstr;

    cmsb_call_timer u_timer (
        .clk    (clk),
        .rst    (rst),
        .start  (timerStart),
        .length (callLength),
        .busy   (callBusy),
        .done   (callDone)
    );

    // ------------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------------
    logic [13:0] pcReg;
    logic [13:0] pcNext;

    // Load has priority over step; the counter wraps at the top of memory.
    always_comb begin
        pcNext = pcReg;
        if (pcLoad) begin
            pcNext = pcLoadValue;
        end else if (pcStep) begin
            pcNext = pcReg + 14'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pcReg <= 14'h0;
        end else begin
            pcReg <= pcNext;
        end
    end

    assign programCounter = pcReg;
endmodule
`default_nettype wire

// ===== sim/cmsb_mode_chk.sv
// Port assertions for the call mode and stack bank select block.
// Assumes it is bound to cmsb_mode_select, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module cmsb_mode_chk (
    // Clock, reset and inputs
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic [11:0]          memAddr,
    input wire logic                 memWrite,
    input wire logic [3:0]           memWdata,
    input wire logic                 callStart,
    input wire cmsb_pkg::cmsb_call_t callKind,
    input wire logic                 pcLoad,
    input wire logic                 pcStep,
    // Observed outputs
    input wire logic                 memHit,
    input wire logic [13:0]          programCounter,
    input wire logic                 extendedMode,
    input wire logic [1:0]           stackBank,
    input wire logic [1:0]           stackEntryBytes,
    input wire logic                 callBusy,
    input wire logic                 callDone
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Calls are judged only when the timer is idle, so a busy timer never trips them.
    a_reset_legacy:
    assert property ($fell(rst) |-> !extendedMode && stackEntryBytes == 2'h2) else $error("not legacy after reset");
    a_mode_write:
    assert property (memWrite && memHit |-> extendedMode == !memWdata[3]) else $error("mode bit misread");
    a_entry_bytes:
    assert property (stackEntryBytes == (extendedMode ? 2'h3 : 2'h2)) else $error("entry size wrong");
    a_bank_write:
    assert property (memWrite && memHit && memWdata[1:0] != 2'h3 |-> stackBank == memWdata[1:0])
        else $error("stack bank wrong");
    a_reg_address:
    assert property (memHit == (memAddr == 12'hf84)) else $error("address decode wrong");
    a_abs_legacy:
    assert property (callStart && callKind == cmsb_pkg::CALL_ABSOLUTE && !callBusy && !extendedMode
        |=> callBusy[*3] ##1 (!callBusy && callDone)) else $error("legacy call length");
    a_abs_extended:
    assert property (callStart && callKind == cmsb_pkg::CALL_ABSOLUTE && !callBusy && extendedMode
        |=> callBusy[*4] ##1 (!callBusy && callDone)) else $error("extended call length");
    a_fixed_legacy:
    assert property (callStart && callKind == cmsb_pkg::CALL_FIXED_AREA && !callBusy && !extendedMode
        |=> callBusy[*2] ##1 !callBusy) else $error("fixed call length");
    a_fixed_extended:
    assert property (callStart && callKind == cmsb_pkg::CALL_FIXED_AREA && !callBusy && extendedMode
        |=> callBusy[*3] ##1 !callBusy) else $error("extended fixed call length");
    a_long_refused:
    assert property (callStart && callKind == cmsb_pkg::CALL_LONG_RANGE && !callBusy && !extendedMode
        |=> !callBusy) else $error("legacy long call started");
    a_pc_step:
    assert property (pcStep && !pcLoad |=> programCounter == $past(programCounter) + 14'h1)
        else $error("counter step wrong");
endmodule
bind cmsb_mode_select cmsb_mode_chk u_chk (.clk, .rst, .memAddr, .memWrite, .memWdata, .callStart, .callKind,
    .pcLoad, .pcStep, .memHit, .programCounter, .extendedMode, .stackBank, .stackEntryBytes, .callBusy, .callDone);
`default_nettype wire

// ===== sim/test_cmsb_mode_select.sv
// Self-checking bench for the call mode and stack bank select block.
// Assumes inputs change at the falling edge, the design samples on the rising one.
`timescale 1ns/1ps
`default_nettype none
module test_cmsb_mode_select;
    logic clk = 0, rst = 1, memWrite = 0, memRead = 0, callStart = 0, longBranchReq = 0, pcLoad = 0, pcStep = 0;
    logic [11:0] memAddr = 12'h0;
    logic [3:0] memWdata = 4'h0, memRdata;
    logic [13:0] pcLoadValue = 14'h0, programCounter;
    logic [1:0] stackBank, stackEntryBytes;
    logic memHit, extendedMode, longInstrAllowed, illegalLongInstr, bankSelectFault, configured, callBusy, callDone;
    cmsb_pkg::cmsb_call_t callKind = cmsb_pkg::CALL_NONE;
    logic [3:0] vals [6] = '{4'h8, 4'h9, 4'ha, 4'h0, 4'h1, 4'h2};
    int num_errors = 0, checks_done = 0;
    cmsb_mode_select DUT (.clk, .rst, .memAddr, .memWrite, .memRead, .memWdata, .memRdata, .memHit, .callStart,
        .callKind, .longBranchReq, .pcLoad, .pcLoadValue, .pcStep, .programCounter, .extendedMode, .stackBank,
        .stackEntryBytes, .longInstrAllowed, .illegalLongInstr, .bankSelectFault, .configured, .callBusy, .callDone);
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    always #20 clk = ~clk;
    task automatic chk(input logic [13:0] seen, input logic [13:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [3:0] d);
        @(negedge clk); memWrite = 1; memAddr = a; memWdata = d;
        @(negedge clk); memWrite = 0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [3:0] e);
        @(negedge clk); memRead = 1; memAddr = a;
        @(negedge clk); memRead = 0;
        chk(memRdata, e, "read data");
    endtask
    // A write may share the call's cycle; the new mode must time that call.
    task automatic call(input cmsb_pkg::cmsb_call_t k, input int n, input logic w, input logic [3:0] d);
        int c;
        c = 0;
        @(negedge clk); callStart = 1; callKind = k;
        if (w) begin
            memWrite = 1; memAddr = 12'hf84; memWdata = d;
        end
        @(negedge clk); callStart = 0; memWrite = 0; callKind = cmsb_pkg::CALL_NONE;
        while (callBusy === 1'b1 && c < 20) begin
            c++;
            @(negedge clk);
        end
        chk(c[13:0], n[13:0], "busy cycles");
        chk(callDone, 1, "call done");
    endtask
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(negedge clk);
        rst = 0;
        chk(extendedMode, 0, "reset mode");
        chk(configured, 0, "unconfigured");
        rd(12'hf84, 4'h8);
        $display("reset test done");
        foreach (vals[i]) begin
            wr(12'hf84, vals[i]);
            chk(extendedMode, !vals[i][3], "mode");
            chk(stackEntryBytes, vals[i][3] ? 2 : 3, "entry bytes");
            chk(stackBank, vals[i][1:0], "bank");
            chk(longInstrAllowed, !vals[i][3], "long allowed");
            rd(12'hf84, vals[i]);
            call(cmsb_pkg::CALL_ABSOLUTE, vals[i][3] ? 3 : 4, 0, 0);
            call(cmsb_pkg::CALL_FIXED_AREA, vals[i][3] ? 2 : 3, 0, 0);
        end
        chk(configured, 1, "configured");
        $display("mode test done");
        wr(12'hf84, 4'h3);
        chk(bankSelectFault, 1, "bank fault");
        call(cmsb_pkg::CALL_LONG_RANGE, 4, 0, 0);
        @(negedge clk); longBranchReq = 1;
        #1 chk(illegalLongInstr, 0, "branch allowed");
        longBranchReq = 0;
        wr(12'hf84, 4'h8);
        @(negedge clk); callStart = 1; callKind = cmsb_pkg::CALL_LONG_RANGE;
        #1 chk(illegalLongInstr, 1, "legacy long");
        @(negedge clk); callStart = 0;
        chk(callBusy, 0, "long refused");
        call(cmsb_pkg::CALL_ABSOLUTE, 4, 1, 4'h0);
        $display("long test done");
        wr(12'hf85, 4'h8);
        rd(12'hf84, 4'h0);
        rd(12'hf85, 4'h0);
        // A reset in mid-run must drop extended mode and the written flag again.
        @(negedge clk); rst = 1;
        @(negedge clk); rst = 0;
        chk(extendedMode, 0, "mid-run reset mode");
        chk(configured, 0, "mid-run reset configured");
        // Load and step together: the load must win.
        @(negedge clk); pcLoad = 1; pcStep = 1; pcLoadValue = 14'h3fff;
        @(negedge clk); pcLoad = 0; pcStep = 1;
        chk(programCounter, 14'h3fff, "pc load");
        @(negedge clk); pcStep = 0;
        chk(programCounter, 14'h0, "pc wrap");
        $display("address and counter test done");
        finish_test();
    end
    // Cut a hang short well past the hundred or so cycles the tests need.
    initial begin
        #200000;
        num_errors++;
        finish_test();
    end
endmodule
`default_nettype wire
